// ===== hw/pvcir_consts.svh
/*
 * constants of the vendor control and interrupt register bank:
 * register indices, field positions, reset values and timing counts.
 * assumes it is included by bare name from the design files and the bench.
 */
`ifndef PVCIR_CONSTS_SVH
`define PVCIR_CONSTS_SVH

// management indices (decimal 27, 29, 30, 31)
`define PVCIR_IDX_XOVER      5'h1B
`define PVCIR_IDX_FLAGS      5'h1D
`define PVCIR_IDX_MASK       5'h1E
`define PVCIR_IDX_SPECIAL    5'h1F

// crossover/polarity control fields
`define PVCIR_B_AUTOX_DIS    15
`define PVCIR_B_PAIR_SWAP    13
`define PVCIR_B_HB_OFF       11
`define PVCIR_B_RX_POL       4

// flag and mask field span
`define PVCIR_EVT_HI         7
`define PVCIR_EVT_LO         1
`define PVCIR_B_EVT_ENERGY   7

// special status fields
`define PVCIR_B_AN_DONE      12
`define PVCIR_B_ENC_EN       6
`define PVCIR_SPD_HI         4
`define PVCIR_SPD_LO         2
`define PVCIR_RSV_HI         11
`define PVCIR_RSV_LO         7

// reset values
`define PVCIR_RST_AUTOX_DIS  1'h0
`define PVCIR_RST_PAIR_SWAP  1'h0
`define PVCIR_RST_HB_OFF     1'h0
`define PVCIR_RST_MASK       7'h00
`define PVCIR_RST_ENC_EN     1'h1
`define PVCIR_RST_RSV        5'h00

// energy timeout: milliseconds, clock in kHz, derived cycle count
`define PVCIR_ENERGY_MS      256
`define PVCIR_CLK_KHZ        100000
`define PVCIR_ENERGY_CYC     (`PVCIR_ENERGY_MS * `PVCIR_CLK_KHZ)

`endif

// ===== hw/pvcir_pkg.sv
/*
 * types shared by the register bank files.
 * assumes nothing beyond a systemverilog compiler.
 */
package pvcir_pkg;

    typedef logic [4:0]  pvcir_idx_t;
    typedef logic [15:0] pvcir_word_t;
    typedef logic [7:1]  pvcir_evt_t;
    typedef logic [24:0] pvcir_cnt_t;

endpackage : pvcir_pkg

// ===== hw/pvcir_energy_timer.sv
/*
 * line energy watchdog: holds the energy-seen status and drops it
 * after a full timeout window with no valid energy.
 * assumes energy_i is synchronous to clk_i.
 */
`timescale 1ns/100ps
`include "pvcir_consts.svh"

module pvcir_energy_timer #(
    parameter int unsigned TIMEOUT_CYC = `PVCIR_ENERGY_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic energy_i,
    output logic      seen_o
);

    pvcir_pkg::pvcir_cnt_t cnt;
    pvcir_pkg::pvcir_cnt_t next_cnt;
    logic                  next_seen;

    // limit held at counter width; default fits 25 bits
    localparam pvcir_pkg::pvcir_cnt_t LIMIT = TIMEOUT_CYC[24:0] - 25'h0000001;

    // energy restarts the window; a soft reset never reaches here
    always_comb
    begin
        next_cnt  = cnt;
        next_seen = seen_o;
        if (energy_i)
        begin
            next_cnt  = 25'h0000000;
            next_seen = 1'b1;
        end
        else if (seen_o)
        begin
            if (cnt >= LIMIT)
                next_seen = 1'b0;
            else
                next_cnt = cnt + 25'h0000001;
        end
    end

    // hardware reset starts with energy assumed present
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt    <= 25'h0000000;
            seen_o <= 1'b1;
        end
        else
        begin
            cnt    <= next_cnt;
            seen_o <= next_seen;
        end
    end

endmodule : pvcir_energy_timer

// ===== hw/pvcir_regs.sv
/*
 * vendor control, interrupt flag/mask and special status registers of
 * a 10/100 transceiver, reached by management index from the smi engine.
 * assumes all inputs come from core logic on clk_i; events are levels.
 */
`timescale 1ns/100ps
`include "pvcir_consts.svh"

module pvcir_regs #(
    parameter int unsigned ENERGY_CYC = `PVCIR_ENERGY_CYC
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    soft_rst_i,
    input  wire pvcir_pkg::pvcir_idx_t   mgmt_idx_i,
    input  wire logic                    mgmt_wr_i,
    input  wire logic                    mgmt_rd_i,
    input  wire pvcir_pkg::pvcir_word_t  mgmt_wdata_i,
    input  wire logic                    rx_polarity_reversed_i,
    input  wire logic                    line_energy_i,
    input  wire logic                    an_done_i,
    input  wire pvcir_pkg::pvcir_evt_t   evt_i,
    input  wire logic [2:0]              resolved_speed_duplex_i,
    input  wire logic                    alt_irq_scheme_i,
    output pvcir_pkg::pvcir_word_t       mgmt_rdata_o,
    output logic                         mgmt_rvalid_o,
    output logic                         auto_crossover_disable_o,
    output logic                         manual_pair_swap_o,
    output logic                         heartbeat_test_off_o,
    output logic                         enc_4b5b_enable_o,
    output logic                         line_energy_seen_o,
    output logic                         irq_o
);

    // index match, used by the read clear and all three write decoders
    function automatic logic hit(input pvcir_pkg::pvcir_idx_t idx,
                                 input pvcir_pkg::pvcir_idx_t target);
        hit = (idx == target);
    endfunction : hit

    pvcir_pkg::pvcir_evt_t  flags;
    pvcir_pkg::pvcir_evt_t  next_flags;
    pvcir_pkg::pvcir_evt_t  mask;
    pvcir_pkg::pvcir_evt_t  next_mask;
    pvcir_pkg::pvcir_evt_t  evt_now;
    pvcir_pkg::pvcir_evt_t  irq_src;
    logic [4:0]             rsv31;
    logic [4:0]             next_rsv31;
    logic                   next_autox;
    logic                   next_swap;
    logic                   next_hb;
    logic                   next_enc;
    logic                   next_irq;
    logic                   energy_q;
    logic                   energy_rise;
    logic                   clr_flags;
    logic                   wr_x;
    logic                   wr_m;
    logic                   wr_s;
    pvcir_pkg::pvcir_word_t next_rdata;

    // energy watchdog drives the status bit straight from its flop
    pvcir_energy_timer #(
        .TIMEOUT_CYC (ENERGY_CYC)
    ) u_energy (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .energy_i (line_energy_i),
        .seen_o   (line_energy_seen_o)
    );

    // bit 7 comes from the rise of energy status, others from core
    assign energy_rise = line_energy_seen_o & ~energy_q;
    assign evt_now     = {energy_rise, evt_i[6:1]};
    assign clr_flags   = mgmt_rd_i & hit(mgmt_idx_i, `PVCIR_IDX_FLAGS);
    assign wr_x        = mgmt_wr_i & hit(mgmt_idx_i, `PVCIR_IDX_XOVER);
    assign wr_m        = mgmt_wr_i & hit(mgmt_idx_i, `PVCIR_IDX_MASK);
    assign wr_s        = mgmt_wr_i & hit(mgmt_idx_i, `PVCIR_IDX_SPECIAL);

    // per-bit latch: a live event beats the read clear
    genvar g;
    generate
        for (g = `PVCIR_EVT_LO; g <= `PVCIR_EVT_HI; g++)
        begin : g_flag
            assign next_flags[g] = (flags[g] & ~clr_flags) | evt_now[g];
            // alternate scheme follows the live source, primary the latch
            assign irq_src[g] = mask[g] & (alt_irq_scheme_i ? evt_now[g] : flags[g]);
        end
    endgenerate

    // writable control; heartbeat bit survives a soft reset
    always_comb
    begin
        next_autox = auto_crossover_disable_o;
        next_swap  = manual_pair_swap_o;
        next_hb    = heartbeat_test_off_o;
        next_enc   = enc_4b5b_enable_o;
        next_mask  = mask;
        next_rsv31 = rsv31;
        if (soft_rst_i)
        begin
            next_autox = `PVCIR_RST_AUTOX_DIS;
            next_swap  = `PVCIR_RST_PAIR_SWAP;
            next_enc   = `PVCIR_RST_ENC_EN;
            next_mask  = `PVCIR_RST_MASK;
            next_rsv31 = `PVCIR_RST_RSV;
        end
        else
        begin
            if (wr_x)
            begin
                next_autox = mgmt_wdata_i[`PVCIR_B_AUTOX_DIS];
                next_swap  = mgmt_wdata_i[`PVCIR_B_PAIR_SWAP];
                next_hb    = mgmt_wdata_i[`PVCIR_B_HB_OFF];
            end
            if (wr_m)
                next_mask = mgmt_wdata_i[`PVCIR_EVT_HI:`PVCIR_EVT_LO];
            if (wr_s)
            begin
                next_enc   = mgmt_wdata_i[`PVCIR_B_ENC_EN];
                next_rsv31 = mgmt_wdata_i[`PVCIR_RSV_HI:`PVCIR_RSV_LO];
            end
        end
        next_irq = |irq_src;
    end

    // read mux; unmapped indices and unused bits read zero, index 31 reserved field reads back
    always_comb
    begin
        next_rdata = 16'h0000;
        case (mgmt_idx_i)
            `PVCIR_IDX_XOVER:
            begin
                next_rdata[`PVCIR_B_AUTOX_DIS] = auto_crossover_disable_o;
                next_rdata[`PVCIR_B_PAIR_SWAP] = manual_pair_swap_o;
                next_rdata[`PVCIR_B_HB_OFF]    = heartbeat_test_off_o;
                next_rdata[`PVCIR_B_RX_POL]    = rx_polarity_reversed_i;
            end
            `PVCIR_IDX_FLAGS:
                next_rdata[`PVCIR_EVT_HI:`PVCIR_EVT_LO] = flags;
            `PVCIR_IDX_MASK:
                next_rdata[`PVCIR_EVT_HI:`PVCIR_EVT_LO] = mask;
            `PVCIR_IDX_SPECIAL:
            begin
                next_rdata[`PVCIR_B_AN_DONE] = an_done_i;
                next_rdata[`PVCIR_RSV_HI:`PVCIR_RSV_LO] = rsv31;
                next_rdata[`PVCIR_B_ENC_EN] = enc_4b5b_enable_o;
                next_rdata[`PVCIR_SPD_HI:`PVCIR_SPD_LO] = resolved_speed_duplex_i;
            end
            default:
                next_rdata = 16'h0000;
        endcase
    end

    // all register state; rdata is held between reads
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            flags                    <= 7'h00;
            mask                     <= `PVCIR_RST_MASK;
            rsv31                    <= `PVCIR_RST_RSV;
            energy_q                 <= 1'b1;
            auto_crossover_disable_o <= `PVCIR_RST_AUTOX_DIS;
            manual_pair_swap_o       <= `PVCIR_RST_PAIR_SWAP;
            heartbeat_test_off_o     <= `PVCIR_RST_HB_OFF;
            enc_4b5b_enable_o        <= `PVCIR_RST_ENC_EN;
            irq_o                    <= 1'b0;
            mgmt_rdata_o             <= 16'h0000;
            mgmt_rvalid_o            <= 1'b0;
        end
        else
        begin
            flags                    <= soft_rst_i ? 7'h00 : next_flags;
            mask                     <= next_mask;
            rsv31                    <= next_rsv31;
            energy_q                 <= line_energy_seen_o;
            auto_crossover_disable_o <= next_autox;
            manual_pair_swap_o       <= next_swap;
            heartbeat_test_off_o     <= next_hb;
            enc_4b5b_enable_o        <= next_enc;
            irq_o                    <= next_irq;
            mgmt_rdata_o             <= mgmt_rd_i ? next_rdata : mgmt_rdata_o;
            mgmt_rvalid_o            <= mgmt_rd_i;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_xover_write: assert property (
        wr_x && !soft_rst_i |=> auto_crossover_disable_o == $past(mgmt_wdata_i[15])
            && manual_pair_swap_o == $past(mgmt_wdata_i[13]))
        else $error("crossover control not written");

    a_hb_soft_keep: assert property (
        soft_rst_i && !wr_x |=> $stable(heartbeat_test_off_o))
        else $error("heartbeat bit disturbed by soft reset");

    a_pol_readback: assert property (
        mgmt_rd_i && mgmt_idx_i == 5'h1B |=> mgmt_rvalid_o
            && mgmt_rdata_o[4] == $past(rx_polarity_reversed_i))
        else $error("polarity readback wrong");

    a_flag_latch: assert property (
        !soft_rst_i && !clr_flags && |flags |=> (flags & $past(flags)) == $past(flags))
        else $error("flag dropped without read");

    a_flag_clear: assert property (
        clr_flags && !soft_rst_i |=> flags == $past(evt_now))
        else $error("read did not clear idle flags");

    a_mask_write: assert property (
        wr_m && !soft_rst_i |=> mask == $past(mgmt_wdata_i[7:1]))
        else $error("mask not written");

    a_irq_primary: assert property (
        !alt_irq_scheme_i ##1 !$past(soft_rst_i)
            |-> irq_o == |($past(flags) & $past(mask)))
        else $error("interrupt request mismatch");

    a_masked_quiet: assert property (
        mask == 7'h00 |=> !irq_o)
        else $error("interrupt with all sources masked");

    a_enc_write: assert property (
        wr_s && !soft_rst_i |=> enc_4b5b_enable_o == $past(mgmt_wdata_i[6]))
        else $error("4b5b enable not written");

    a_special_read: assert property (
        mgmt_rd_i && mgmt_idx_i == 5'h1F |=> mgmt_rdata_o[4:2]
            == $past(resolved_speed_duplex_i) && mgmt_rdata_o[12] == $past(an_done_i))
        else $error("special status readback wrong");

    a_energy_flag: assert property (
        energy_rise && !soft_rst_i |=> flags[7])
        else $error("energy event not latched");

endmodule : pvcir_regs

// ===== tb/pvcir_mgmt_model.sv
/*
 * station management master model: issues one register access at a time.
 * assumes the bank takes a strobe at the rising edge after it is raised.
 */
`timescale 1ns/100ps

module pvcir_mgmt_model (
    input  wire logic             clk_i,
    output pvcir_pkg::pvcir_idx_t mgmt_idx_o,
    output logic                  mgmt_wr_o,
    output logic                  mgmt_rd_o,
    output pvcir_pkg::pvcir_word_t mgmt_wdata_o
);
    initial
    begin
        mgmt_idx_o   = 5'h00;
        mgmt_wr_o    = 1'b0;
        mgmt_rd_o    = 1'b0;
        mgmt_wdata_o = 16'h0000;
    end

    // 4B5B control is only touched with the mac side in mii mode
    task automatic access(input logic is_wr, input pvcir_pkg::pvcir_idx_t idx,
                          input pvcir_pkg::pvcir_word_t data);
        @(posedge clk_i);
        mgmt_idx_o   <= idx;
        mgmt_wr_o    <= is_wr;
        mgmt_rd_o    <= ~is_wr;
        mgmt_wdata_o <= data;
        @(posedge clk_i);
        mgmt_wr_o    <= 1'b0;
        mgmt_rd_o    <= 1'b0;
        // released lines must not keep showing the last value
        mgmt_idx_o   <= ~idx;
        mgmt_wdata_o <= ~data;
    endtask : access
endmodule : pvcir_mgmt_model

// ===== tb/test_phy_vendor_ctrl_irq_regs.sv
/*
 * self-checking bench of the vendor register bank.
 * assumes the management model above and a short energy timeout.
 */
`timescale 1ns/100ps
`include "pvcir_consts.svh"
`define CHK(nm, e, g) chk(nm, 16'(e), 16'(g))

module test_phy_vendor_ctrl_irq_regs;
    localparam int unsigned ENERGY_CYC = 20;
    logic clk_i = 1'b0, rst_n_i = 1'b0, soft_rst_i = 1'b0, pol = 1'b0, energy = 1'b1;
    logic an = 1'b0, alt = 1'b0, rvalid, autox, swap, hb, enc, seen, irq, wr, rd;
    logic [2:0] spd = 3'b001;
    logic [2:0] codes [4] = '{3'b001, 3'b101, 3'b010, 3'b110};
    pvcir_pkg::pvcir_evt_t  evt = 7'h00;
    pvcir_pkg::pvcir_idx_t  idx;
    pvcir_pkg::pvcir_word_t wdata, rdata, r, e_w;
    pvcir_pkg::pvcir_word_t exp_q [$];
    int fail_count = 0;
    int tests_run = 0;

    always #5 clk_i = ~clk_i;

    pvcir_mgmt_model i_pvcir_mgmt_model (.clk_i(clk_i), .mgmt_idx_o(idx), .mgmt_wr_o(wr),
        .mgmt_rd_o(rd), .mgmt_wdata_o(wdata));
    pvcir_regs #(.ENERGY_CYC(ENERGY_CYC)) i_pvcir_regs (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .soft_rst_i(soft_rst_i), .mgmt_idx_i(idx), .mgmt_wr_i(wr), .mgmt_rd_i(rd),
        .mgmt_wdata_i(wdata), .rx_polarity_reversed_i(pol), .line_energy_i(energy),
        .an_done_i(an), .evt_i(evt), .resolved_speed_duplex_i(spd),
        .alt_irq_scheme_i(alt), .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid),
        .auto_crossover_disable_o(autox), .manual_pair_swap_o(swap),
        .heartbeat_test_off_o(hb), .enc_4b5b_enable_o(enc), .line_energy_seen_o(seen),
        .irq_o(irq));

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    // read notes its expectation first, the monitor settles it later
    task automatic rd_x(input pvcir_pkg::pvcir_idx_t a, input pvcir_pkg::pvcir_word_t e);
        exp_q.push_back(e);
        i_pvcir_mgmt_model.access(1'b0, a, 16'h0000);
    endtask : rd_x

    task automatic wr_x(input pvcir_pkg::pvcir_idx_t a, input pvcir_pkg::pvcir_word_t d);
        i_pvcir_mgmt_model.access(1'b1, a, d);
    endtask : wr_x

    function automatic pvcir_pkg::pvcir_word_t x27(input logic a, s, h);
        return {a, 1'b0, s, 1'b0, h, 6'h00, pol, 4'h0};
    endfunction : x27

    function automatic pvcir_pkg::pvcir_word_t x31(input logic en);
        return {3'h0, an, 5'h00, en, 1'b0, spd, 2'h0};
    endfunction : x31

    // one edge-wide event pulse, then time for flag and irq to settle
    task automatic pulse(input int k);
        evt[k] <= 1'b1;
        cyc(1);
        evt <= 7'h00;
        cyc(3);
    endtask : pulse

    // every read answer is matched against the oldest note
    always @(posedge clk_i)
    begin
        if (rvalid === 1'b1)
        begin
            e_w = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hDEAD;
            `CHK("mgmt_rdata_o", e_w, rdata);
        end
    end

    // watchdog sized well beyond the expected few hundred cycles
    initial
    begin
        #100000;
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        r = 16'($urandom(32'hF2E0));
        cyc(16);
        rst_n_i <= 1'b1;
        cyc(1);
        `CHK("reset outputs", 6'b000110, {autox, swap, hb, enc, seen, irq});
        rd_x(`PVCIR_IDX_XOVER, 16'h0000);
        rd_x(`PVCIR_IDX_FLAGS, 16'h0000);
        rd_x(`PVCIR_IDX_MASK, 16'h0000);
        rd_x(`PVCIR_IDX_SPECIAL, x31(1'b1));
        rd_x(5'h1C, 16'h0000);
        for (int p = 0; p < 2; p++)
        begin
            pol <= p[0];
            wr_x(`PVCIR_IDX_XOVER, 16'hFFFF);
            rd_x(`PVCIR_IDX_XOVER, x27(1'b1, 1'b1, 1'b1));
        end
        pol <= 1'b0;
        `CHK("xover outputs", 3'b111, {autox, swap, hb});
        wr_x(`PVCIR_IDX_XOVER, 16'h2000);
        cyc(1);
        `CHK("pair outputs", 3'b010, {autox, swap, hb});
        wr_x(`PVCIR_IDX_FLAGS, 16'hFFFF);
        rd_x(`PVCIR_IDX_FLAGS, 16'h0000);
        r = 16'($urandom);
        wr_x(`PVCIR_IDX_MASK, r);
        rd_x(`PVCIR_IDX_MASK, r & 16'h00FE);
        for (int i = 0; i < 4; i++)
        begin
            spd <= codes[i];
            an  <= i[0];
            cyc(1);
            rd_x(`PVCIR_IDX_SPECIAL, x31(1'b1));
        end
        // bypass only with the mac side in mii mode
        wr_x(`PVCIR_IDX_SPECIAL, 16'h0000);
        rd_x(`PVCIR_IDX_SPECIAL, x31(1'b0));
        `CHK("enc_4b5b_enable_o", 1'b0, enc);
        wr_x(`PVCIR_IDX_MASK, 16'h00FE);
        for (int k = 1; k < 7; k++)
        begin
            pulse(k);
            `CHK("irq_o set", 1'b1, irq);
            rd_x(`PVCIR_IDX_FLAGS, 16'(1 << k));
            cyc(2);
            `CHK("irq_o cleared", 1'b0, irq);
            rd_x(`PVCIR_IDX_FLAGS, 16'h0000);
        end
        wr_x(`PVCIR_IDX_MASK, 16'h0004);
        pulse(3);
        `CHK("irq_o other bit", 1'b0, irq);
        pulse(2);
        `CHK("irq_o same bit", 1'b1, irq);
        rd_x(`PVCIR_IDX_FLAGS, 16'h000C);
        evt[5] <= 1'b1;
        rd_x(`PVCIR_IDX_FLAGS, 16'h0020);
        rd_x(`PVCIR_IDX_FLAGS, 16'h0020);
        evt <= 7'h00;
        cyc(2);
        rd_x(`PVCIR_IDX_FLAGS, 16'h0020);
        rd_x(`PVCIR_IDX_FLAGS, 16'h0000);
        alt <= 1'b1;
        evt[2] <= 1'b1;
        cyc(3);
        `CHK("irq_o alternate", 1'b1, irq);
        evt <= 7'h00;
        cyc(3);
        `CHK("irq_o alternate off", 1'b0, irq);
        alt <= 1'b0;
        rd_x(`PVCIR_IDX_FLAGS, 16'h0004);
        energy <= 1'b0;
        cyc(ENERGY_CYC + 5);
        `CHK("line_energy_seen_o low", 1'b0, seen);
        energy <= 1'b1;
        cyc(3);
        `CHK("line_energy_seen_o high", 1'b1, seen);
        rd_x(`PVCIR_IDX_FLAGS, 16'h0080);
        rd_x(`PVCIR_IDX_FLAGS, 16'h0000);
        wr_x(`PVCIR_IDX_XOVER, 16'hA800);
        wr_x(`PVCIR_IDX_MASK, 16'h00FE);
        soft_rst_i <= 1'b1;
        cyc(1);
        soft_rst_i <= 1'b0;
        cyc(2);
        rd_x(`PVCIR_IDX_XOVER, x27(1'b0, 1'b0, 1'b1));
        rd_x(`PVCIR_IDX_MASK, 16'h0000);
        rd_x(`PVCIR_IDX_SPECIAL, x31(1'b1));
        `CHK("seen after soft reset", 1'b1, seen);
        // let the last read answer land before the hard reset wipes it
        cyc(2);
        rst_n_i <= 1'b0;
        cyc(2);
        `CHK("hard reset outputs", 6'b000110, {autox, swap, hb, enc, seen, irq});
        rst_n_i <= 1'b1;
        cyc(4);
        `CHK("pending reads", 0, exp_q.size());
        tally_and_finish();
    end
endmodule : test_phy_vendor_ctrl_irq_regs
